// ### rtl/pft_pkg.sv
// constants, enumerations and carriers of the program flash table access unit
// assumes a single 40 MHz system clock and a byte-wide register port
// Overview of operation
// - byte reads, 8-byte programs (one byte to eeprom), 64-byte erases
// - no bulk erase, only row erase
// - stall fetch while programming, timer ends
// - all transfers pass the 8-bit latch
// - table write fills holding register only
// - unlock register unstored, reads as zero
// - bit 7 picks flash or eeprom
// - bit 6 picks configuration space first
// - bit 4 erases row, cleared after
// - bit 2 gates writes, clear at reset
// - bit 3 shows improper write, cleared by reset
// - error set at start, cleared at completion
// - start bit settable only, hardware clears
// - bit 0 reads eeprom, refused otherwise
// - done flag bit 4 set, software clears
// - error keeps space select bits intact
// - 22-bit pointer from three bytes
// - pointer steps touch low 21 bits
// - table read uses all 22 bits
// - bits 2:0 pick holding, 21:3 block
// - erase uses bits 21:6, ignores 5:0
// - four pointer modes per table op
// - holding bytes reset to FFh, FFh unchanged
package pft_pkg;

    localparam int          BUS_AW        = 3;
    localparam logic [2:0]  OFS_CONTROL   = 3'h0;
    localparam logic [2:0]  OFS_UNLOCK    = 3'h1;
    localparam logic [2:0]  OFS_LATCH     = 3'h2;
    localparam logic [2:0]  OFS_PTR_LOW   = 3'h3;
    localparam logic [2:0]  OFS_PTR_HIGH  = 3'h4;
    localparam logic [2:0]  OFS_PTR_UPPER = 3'h5;
    localparam logic [2:0]  OFS_PFLAG_TWO = 3'h6;

    localparam int BIT_PGM_SEL = 7;
    localparam int BIT_CFG_SEL = 6;
    localparam int BIT_ERASE   = 4;
    localparam int BIT_ERROR   = 3;
    localparam int BIT_PROGRAM_WRITE_ENABLE    = 2;
    localparam int BIT_WR      = 1;
    localparam int BIT_RD      = 0;
    localparam int BIT_DONE    = 4;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] HOLD_RESET  = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    localparam int PTR_W      = 22;
    localparam int PTR_STEP_W = 21;
    localparam int HOLD_N     = 8;

    localparam int CLK_FREQ_HZ  = 40_000_000;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES  = PROG_TIME_US * (CLK_FREQ_HZ / 1_000_000);

    typedef enum logic [1:0] {
        PM_KEEP    = 2'b00,
        PM_POSTINC = 2'b01,
        PM_POSTDEC = 2'b10,
        PM_PREINC  = 2'b11
    } pft_ptr_mode_e;

    typedef enum logic [1:0] {
        TGT_EEPROM = 2'b00,
        TGT_FLASH  = 2'b01,
        TGT_CONFIG = 2'b10
    } pft_target_e;

    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_FL_WAIT = 2'b01,
        SEQ_EE_WAIT = 2'b10
    } pft_seq_e;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [BUS_AW-1:0] addr;
        logic [7:0]        wdata;
    } pft_bus_req_s;

    typedef struct packed {
        logic              commit;
        logic              erase;
        pft_target_e       target;
        logic [PTR_W-1:0]  addr;
        logic [63:0]       data;
        logic [7:0]        byte_en;
    } pft_prog_s;

endpackage

// ### rtl/pft_top.sv
// program flash table access unit: latch, pointer, holding bytes, timed sequencer
// assumes memory read data arrive in the same cycle as the read pulse
`timescale 1ns/1ps
`default_nettype none

module pft_top #(
    parameter int P_PROG_CYCLES = pft_pkg::PROG_CYCLES
) (
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_nrst,
    input  wire pft_pkg::pft_bus_req_s         i_bus,
    output logic [7:0]                         o_bus_rdata,
    input  wire logic                          i_tbl_req,
    input  wire logic                          i_tbl_write,
    input  wire pft_pkg::pft_ptr_mode_e        i_tbl_mode,
    output logic                               o_tbl_done,
    output logic                               o_fetch_stall,
    output logic                               o_flash_rd,
    output logic [pft_pkg::PTR_W-1:0]          o_flash_rd_addr,
    input  wire logic [7:0]                    i_flash_rdata,
    output logic                               o_ee_rd,
    output logic [pft_pkg::PTR_W-1:0]          o_ee_rd_addr,
    input  wire logic [7:0]                    i_ee_rdata,
    output pft_pkg::pft_prog_s                 o_prog
);

    typedef struct packed {
        logic                          pgm_sel;
        logic                          cfg_sel;
        logic                          erase_en;
        logic                          err;
        logic                          program_write_enable;
        logic                          wr;
        logic                          rd;
        logic                          key1_seen;
        logic                          armed;
        logic [7:0]                    latch;
        logic [pft_pkg::PTR_W-1:0]     ptr;
        logic [7:0][7:0]               hold;
        logic                          done_flag;
        logic                          busy;
        logic [31:0]                   cnt;
        pft_pkg::pft_seq_e             seq;
        logic [7:0]                    rdata;
        logic                          tbl_done;
        logic                          flash_rd;
        logic [pft_pkg::PTR_W-1:0]     flash_addr;
        logic                          ee_rd;
        pft_pkg::pft_prog_s            prog;
    } pft_state_s;

    pft_state_s s_r;
    pft_state_s s_nxt;

    logic [pft_pkg::PTR_STEP_W-1:0] low_pre;
    logic [pft_pkg::PTR_STEP_W-1:0] low_post;
    logic [pft_pkg::PTR_W-1:0]      eff_addr;
    pft_pkg::pft_target_e           tgt;
    logic                           start_try;
    logic                           rd_try;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tbl_done = 1'b0;
        s_nxt.flash_rd = 1'b0;
        s_nxt.ee_rd = 1'b0;
        s_nxt.prog.commit = 1'b0;
        s_nxt.rdata = 8'h00;
        start_try = 1'b0;
        rd_try = 1'b0;
        tgt = pft_pkg::TGT_EEPROM;
        low_pre = s_r.ptr[pft_pkg::PTR_STEP_W-1:0];
        low_post = s_r.ptr[pft_pkg::PTR_STEP_W-1:0];
        eff_addr = s_r.ptr;

        if (i_bus.rd)
        begin
            case (i_bus.addr)
                pft_pkg::OFS_CONTROL:
                begin
                    s_nxt.rdata = {s_r.pgm_sel, s_r.cfg_sel, 1'b0, s_r.erase_en,
                                   s_r.err, s_r.program_write_enable, s_r.wr, s_r.rd};
                end
                pft_pkg::OFS_UNLOCK:    s_nxt.rdata = 8'h00;
                pft_pkg::OFS_LATCH:     s_nxt.rdata = s_r.latch;
                pft_pkg::OFS_PTR_LOW:   s_nxt.rdata = s_r.ptr[7:0];
                pft_pkg::OFS_PTR_HIGH:  s_nxt.rdata = s_r.ptr[15:8];
                pft_pkg::OFS_PTR_UPPER: s_nxt.rdata = {2'b00, s_r.ptr[21:16]};
                pft_pkg::OFS_PFLAG_TWO: s_nxt.rdata = {3'b000, s_r.done_flag, 4'b0000};
                default:                s_nxt.rdata = 8'h00;
            endcase
        end

        if (i_bus.wr)
        begin
            case (i_bus.addr)
                pft_pkg::OFS_CONTROL:
                begin
                    // control is frozen while a timed cycle runs
                    if (!s_r.busy)
                    begin
                        s_nxt.pgm_sel = i_bus.wdata[pft_pkg::BIT_PGM_SEL];
                        s_nxt.cfg_sel = i_bus.wdata[pft_pkg::BIT_CFG_SEL];
                        s_nxt.erase_en = i_bus.wdata[pft_pkg::BIT_ERASE];
                        s_nxt.err = i_bus.wdata[pft_pkg::BIT_ERROR];
                        s_nxt.program_write_enable = i_bus.wdata[pft_pkg::BIT_PROGRAM_WRITE_ENABLE];
                        start_try = i_bus.wdata[pft_pkg::BIT_WR];
                        rd_try = i_bus.wdata[pft_pkg::BIT_RD] && !start_try;
                    end
                end
                pft_pkg::OFS_UNLOCK:
                begin
                    // any stray byte breaks the sequence
                    s_nxt.key1_seen = (i_bus.wdata == pft_pkg::UNLOCK_KEY1);
                    s_nxt.armed = s_r.key1_seen && (i_bus.wdata == pft_pkg::UNLOCK_KEY2);
                end
                pft_pkg::OFS_LATCH:     s_nxt.latch = i_bus.wdata;
                pft_pkg::OFS_PTR_LOW:   s_nxt.ptr[7:0] = i_bus.wdata;
                pft_pkg::OFS_PTR_HIGH:  s_nxt.ptr[15:8] = i_bus.wdata;
                pft_pkg::OFS_PTR_UPPER: s_nxt.ptr[21:16] = i_bus.wdata[5:0];
                pft_pkg::OFS_PFLAG_TWO: s_nxt.done_flag = i_bus.wdata[pft_pkg::BIT_DONE];
                default:                s_nxt.done_flag = s_nxt.done_flag;
            endcase
        end

        // space select: configuration wins over program/eeprom choice
        if (s_nxt.cfg_sel)
        begin
            tgt = pft_pkg::TGT_CONFIG;
        end
        else if (s_nxt.pgm_sel)
        begin
            tgt = pft_pkg::TGT_FLASH;
        end
        else
        begin
            tgt = pft_pkg::TGT_EEPROM;
        end

        if (start_try)
        begin
            s_nxt.armed = 1'b0;
            s_nxt.key1_seen = 1'b0;
            s_nxt.err = 1'b1;
            if (s_nxt.program_write_enable && s_r.armed)
            begin
                s_nxt.wr = 1'b1;
                s_nxt.busy = 1'b1;
                s_nxt.cnt = 32'(P_PROG_CYCLES - 1);
                s_nxt.prog.target = tgt;
                // only a row erase exists, and only on the flash array
                s_nxt.prog.erase = s_nxt.erase_en && (tgt == pft_pkg::TGT_FLASH);
                if (s_nxt.prog.erase)
                begin
                    s_nxt.prog.addr = {s_nxt.ptr[21:6], 6'b00_0000};
                    s_nxt.prog.data = {8{pft_pkg::HOLD_RESET}};
                    s_nxt.prog.byte_en = 8'h00;
                end
                else if (tgt == pft_pkg::TGT_EEPROM)
                begin
                    s_nxt.prog.addr = s_nxt.ptr;
                    s_nxt.prog.data = {{7{pft_pkg::HOLD_RESET}}, s_nxt.latch};
                    s_nxt.prog.byte_en = 8'h01;
                end
                else
                begin
                    s_nxt.prog.addr = {s_nxt.ptr[21:3], 3'b000};
                    s_nxt.prog.data = s_r.hold;
                    for (int i = 0; i < pft_pkg::HOLD_N; i++)
                    begin
                        s_nxt.prog.byte_en[i] = (s_r.hold[i] != pft_pkg::HOLD_RESET);
                    end
                end
            end
        end

        // eeprom read refused for program or configuration space
        if (rd_try && !s_nxt.pgm_sel && !s_nxt.cfg_sel && s_r.seq == pft_pkg::SEQ_IDLE)
        begin
            s_nxt.rd = 1'b1;
            s_nxt.ee_rd = 1'b1;
            s_nxt.flash_addr = s_nxt.ptr;
            s_nxt.seq = pft_pkg::SEQ_EE_WAIT;
        end

        // end of the timed cycle; sel bits are never touched here
        if (s_r.busy)
        begin
            if (s_r.cnt == 32'h0000_0000)
            begin
                s_nxt.busy = 1'b0;
                s_nxt.wr = 1'b0;
                s_nxt.err = 1'b0;
                s_nxt.prog.commit = 1'b1;
                s_nxt.done_flag = 1'b1;
                if (s_r.prog.erase)
                begin
                    s_nxt.erase_en = 1'b0;
                end
                s_nxt.hold = {pft_pkg::HOLD_N{pft_pkg::HOLD_RESET}};
            end
            else
            begin
                s_nxt.cnt = s_r.cnt - 32'h0000_0001;
            end
        end

        case (s_r.seq)
            pft_pkg::SEQ_IDLE:
            begin
                // table ops need the array, so they wait out a timed cycle
                if (i_tbl_req && !s_r.busy && s_nxt.seq == pft_pkg::SEQ_IDLE)
                begin
                    if (i_tbl_mode == pft_pkg::PM_PREINC)
                    begin
                        low_pre = s_nxt.ptr[pft_pkg::PTR_STEP_W-1:0] + 21'h00_0001;
                    end
                    else
                    begin
                        low_pre = s_nxt.ptr[pft_pkg::PTR_STEP_W-1:0];
                    end
                    eff_addr = {s_nxt.ptr[21], low_pre};
                    case (i_tbl_mode)
                        pft_pkg::PM_POSTINC: low_post = low_pre + 21'h00_0001;
                        pft_pkg::PM_POSTDEC: low_post = low_pre - 21'h00_0001;
                        default:             low_post = low_pre;
                    endcase
                    s_nxt.ptr = {s_nxt.ptr[21], low_post};
                    if (i_tbl_write)
                    begin
                        s_nxt.hold[eff_addr[2:0]] = s_nxt.latch;
                        s_nxt.tbl_done = 1'b1;
                    end
                    else
                    begin
                        s_nxt.flash_rd = 1'b1;
                        s_nxt.flash_addr = eff_addr;
                        s_nxt.seq = pft_pkg::SEQ_FL_WAIT;
                    end
                end
            end
            pft_pkg::SEQ_FL_WAIT:
            begin
                s_nxt.latch = i_flash_rdata;
                s_nxt.tbl_done = 1'b1;
                s_nxt.seq = pft_pkg::SEQ_IDLE;
            end
            pft_pkg::SEQ_EE_WAIT:
            begin
                s_nxt.latch = i_ee_rdata;
                s_nxt.rd = 1'b0;
                s_nxt.seq = pft_pkg::SEQ_IDLE;
            end
            default:
            begin
                s_nxt.seq = pft_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_r <= '0;
            s_r.latch <= pft_pkg::LATCH_RESET;
            s_r.hold <= {pft_pkg::HOLD_N{pft_pkg::HOLD_RESET}};
            s_r.seq <= pft_pkg::SEQ_IDLE;
            s_r.prog.target <= pft_pkg::TGT_EEPROM;
            s_r.prog.data <= {8{pft_pkg::HOLD_RESET}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign o_bus_rdata = s_r.rdata;
    assign o_tbl_done = s_r.tbl_done;
    assign o_fetch_stall = s_r.busy;
    assign o_flash_rd = s_r.flash_rd;
    assign o_flash_rd_addr = s_r.flash_addr;
    assign o_ee_rd = s_r.ee_rd;
    assign o_ee_rd_addr = s_r.flash_addr;
    assign o_prog = s_r.prog;

endmodule

`default_nettype wire

// ### verif/pft_monitor.sv
// concurrent checks on the table access unit, from its top-level ports only
// assumes one clock domain with an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module pft_monitor #(
    parameter int P_PROG_CYCLES = 8
) (
    input wire logic                         i_sys_clk,
    input wire logic                         i_nrst,
    input wire pft_pkg::pft_bus_req_s        i_bus,
    input wire logic [7:0]                   o_bus_rdata,
    input wire logic                         i_tbl_req,
    input wire logic                         i_tbl_write,
    input wire pft_pkg::pft_ptr_mode_e       i_tbl_mode,
    input wire logic                         o_tbl_done,
    input wire logic                         o_fetch_stall,
    input wire logic                         o_flash_rd,
    input wire logic [pft_pkg::PTR_W-1:0]    o_flash_rd_addr,
    input wire logic [7:0]                   i_flash_rdata,
    input wire logic                         o_ee_rd,
    input wire logic [pft_pkg::PTR_W-1:0]    o_ee_rd_addr,
    input wire logic [7:0]                   i_ee_rdata,
    input wire pft_pkg::pft_prog_s           o_prog
);
    // counts stall cycles; timed cycles exceed any unrollable repetition
    logic [31:0] stall_cnt_r;
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst) stall_cnt_r <= '0;
        else stall_cnt_r <= o_fetch_stall ? stall_cnt_r + 32'h1 : '0;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    unlock_reads_zero_a: assert property (
        $past(i_bus.rd && i_bus.addr == pft_pkg::OFS_UNLOCK) |-> o_bus_rdata == 8'h00)
        else $error("unlock register read not zero");
    stall_length_a: assert property (
        $fell(o_fetch_stall) |-> stall_cnt_r == 32'(P_PROG_CYCLES))
        else $error("timed cycle length wrong");
    commit_at_end_a: assert property (
        o_prog.commit |-> $fell(o_fetch_stall))
        else $error("commit outside end of timed cycle");
    stall_cause_a: assert property (
        $rose(o_fetch_stall) |->
            $past(i_bus.wr && i_bus.addr == pft_pkg::OFS_CONTROL && i_bus.wdata[1]))
        else $error("timed cycle began without a start write");
    read_cause_a: assert property (
        o_flash_rd |-> $past(i_tbl_req && !i_tbl_write))
        else $error("memory read without table read request");
    read_done_a: assert property (
        o_flash_rd |=> o_tbl_done && !o_flash_rd)
        else $error("table read did not finish next cycle");
    write_done_a: assert property (
        i_tbl_req && i_tbl_write && !o_fetch_stall && !o_flash_rd && !o_ee_rd
            && !(i_bus.wr && i_bus.addr == pft_pkg::OFS_CONTROL && i_bus.wdata[0])
            |=> o_tbl_done)
        else $error("table write not acknowledged next cycle");
    erase_row_a: assert property (
        o_fetch_stall && o_prog.erase |-> o_prog.addr[5:0] == 6'h00 && o_prog.byte_en == 8'h00)
        else $error("erase address not row aligned");
    block_aligned_a: assert property (
        o_fetch_stall && !o_prog.erase && o_prog.target != pft_pkg::TGT_EEPROM
            |-> o_prog.addr[2:0] == 3'h0)
        else $error("program block not aligned");
    erase_flash_a: assert property (
        o_fetch_stall && o_prog.erase |-> o_prog.target == pft_pkg::TGT_FLASH)
        else $error("erase outside flash array");
endmodule

bind pft_top pft_monitor #(.P_PROG_CYCLES(P_PROG_CYCLES)) pft_monitor_inst (
    .i_sys_clk       (i_sys_clk),
    .i_nrst          (i_nrst),
    .i_bus           (i_bus),
    .o_bus_rdata     (o_bus_rdata),
    .i_tbl_req       (i_tbl_req),
    .i_tbl_write     (i_tbl_write),
    .i_tbl_mode      (i_tbl_mode),
    .o_tbl_done      (o_tbl_done),
    .o_fetch_stall   (o_fetch_stall),
    .o_flash_rd      (o_flash_rd),
    .o_flash_rd_addr (o_flash_rd_addr),
    .i_flash_rdata   (i_flash_rdata),
    .o_ee_rd         (o_ee_rd),
    .o_ee_rd_addr    (o_ee_rd_addr),
    .i_ee_rdata      (i_ee_rdata),
    .o_prog          (o_prog)
);
`default_nettype wire

// ### verif/pft_mem_model.sv
// behavioural program flash and eeprom read ports behind the access unit
// data is a fixed mix of the address; valid in the read cycle and the two after it
`timescale 1ns/1ps
`default_nettype none
module pft_mem_model (
    input  wire logic        i_sys_clk,
    input  wire logic        i_flash_rd,
    input  wire logic [21:0] i_flash_addr,
    input  wire logic        i_ee_rd,
    input  wire logic [21:0] i_ee_addr,
    output logic [7:0]       o_flash_rdata,
    output logic [7:0]       o_ee_rdata
);
    logic [7:0] fl_r = 8'h00;
    logic [7:0] ee_r = 8'h00;
    logic       fl_hold_r = 1'b0;
    logic       ee_hold_r = 1'b0;
    // outside the valid window the bytes toggle so a late sample shows
    always_ff @(posedge i_sys_clk)
    begin
        fl_hold_r <= i_flash_rd;
        ee_hold_r <= i_ee_rd;
        fl_r <= i_flash_rd ? o_flash_rdata : (fl_hold_r ? fl_r : ~fl_r);
        ee_r <= i_ee_rd ? o_ee_rdata : (ee_hold_r ? ee_r : ~ee_r);
    end
    assign o_flash_rdata = i_flash_rd ? i_flash_addr[7:0] ^ 8'h5A : fl_r;
    assign o_ee_rdata    = i_ee_rd ? i_ee_addr[7:0] ^ 8'hC3 : ee_r;
endmodule
`default_nettype wire

// ### verif/program_flash_table_access_tb.sv
// self-checking bench for the table access unit over its register port
// assumes the memory model answers reads; timed cycles shortened to 8
`timescale 1ns/1ps
`default_nettype none
module program_flash_table_access_tb;
    logic                          clk = 1'b0;
    logic                          nrst = 1'b0;
    pft_pkg::pft_bus_req_s         bus = '0;
    logic                          req = 1'b0;
    logic                          tw = 1'b0;
    pft_pkg::pft_ptr_mode_e        mode = pft_pkg::PM_KEEP;
    logic [7:0]                    o_bus_rdata, fl_d, ee_d;
    logic                          o_tbl_done, o_fetch_stall, o_flash_rd, o_ee_rd;
    logic [21:0]                   o_flash_rd_addr, o_ee_rd_addr, rd_seen;
    pft_pkg::pft_prog_s            o_prog, prog_seen;
    int                            miscompares = 0, checked = 0, cyc = 0;
    int                            stall_n = 0, stall_d = 0, ee_n = 0;

    pft_top #(.P_PROG_CYCLES(8)) pft_top_inst (
        .i_sys_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_bus_rdata(o_bus_rdata),
        .i_tbl_req(req), .i_tbl_write(tw), .i_tbl_mode(mode), .o_tbl_done(o_tbl_done),
        .o_fetch_stall(o_fetch_stall), .o_flash_rd(o_flash_rd),
        .o_flash_rd_addr(o_flash_rd_addr), .i_flash_rdata(fl_d), .o_ee_rd(o_ee_rd),
        .o_ee_rd_addr(o_ee_rd_addr), .i_ee_rdata(ee_d), .o_prog(o_prog));
    pft_mem_model pft_mem_model_inst (
        .i_sys_clk(clk), .i_flash_rd(o_flash_rd), .i_flash_addr(o_flash_rd_addr),
        .i_ee_rd(o_ee_rd), .i_ee_addr(o_ee_rd_addr), .o_flash_rdata(fl_d),
        .o_ee_rdata(ee_d));

    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (o_fetch_stall) prog_seen <= o_prog;
        if (o_fetch_stall) stall_n <= stall_n + 1;
        if (o_flash_rd) rd_seen <= o_flash_rd_addr;
        if (o_ee_rd) ee_n <= ee_n + 1;
        cyc <= cyc + 1;
        // whole run needs about 320 cycles
        if (cyc == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        chk(64'(o_bus_rdata), 64'(exp));
    endtask
    task automatic setp(input logic [21:0] p);
        wr(pft_pkg::OFS_PTR_LOW, p[7:0]);
        wr(pft_pkg::OFS_PTR_HIGH, p[15:8]);
        wr(pft_pkg::OFS_PTR_UPPER, {2'b11, p[21:16]});
    endtask
    task automatic chkp(input logic [21:0] p);
        rdc(pft_pkg::OFS_PTR_LOW, p[7:0]);
        rdc(pft_pkg::OFS_PTR_HIGH, p[15:8]);
        rdc(pft_pkg::OFS_PTR_UPPER, {2'b00, p[21:16]});
    endtask
    task automatic tbl(input logic w, input pft_pkg::pft_ptr_mode_e m);
        @(posedge clk);
        req <= 1'b1;
        tw <= w;
        mode <= m;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic prog(input logic [7:0] ctl, input logic unl);
        int n0;
        n0 = stall_n;
        if (unl)
        begin
            wr(pft_pkg::OFS_UNLOCK, pft_pkg::UNLOCK_KEY1);
            wr(pft_pkg::OFS_UNLOCK, pft_pkg::UNLOCK_KEY2);
        end
        wr(pft_pkg::OFS_CONTROL, ctl);
        repeat (14) @(posedge clk);
        stall_d = stall_n - n0;
    endtask
    function automatic logic [21:0] stp(input logic [21:0] p, input logic up);
        return {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
    endfunction

    initial
    begin
        logic [21:0] a;
        automatic logic [7:0] ictl[3] = '{8'h86, 8'h82, 8'hC6};
        automatic logic [7:0] iexp[3] = '{8'h8C, 8'h88, 8'hCC};
        automatic logic [7:0] tctl[3] = '{8'h06, 8'hC6, 8'h46};
        automatic pft_pkg::pft_target_e ttg[3] = '{pft_pkg::TGT_EEPROM, pft_pkg::TGT_CONFIG,
                                                   pft_pkg::TGT_CONFIG};
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdc(pft_pkg::OFS_CONTROL, 8'h00);
        rdc(pft_pkg::OFS_UNLOCK, 8'h00);
        wr(3'h7, 8'hA5);
        rdc(3'h7, 8'h00);
        // all-ones low part makes post-increment wrap without touching bit 21
        for (int m = 0; m < 4; m++)
        begin
            setp(22'h3F_FFFF);
            tbl(1'b0, pft_pkg::pft_ptr_mode_e'(m));
            a = (m == 3) ? stp(22'h3F_FFFF, 1'b1) : 22'h3F_FFFF;
            chk(64'(rd_seen), 64'(a));
            rdc(pft_pkg::OFS_LATCH, a[7:0] ^ 8'h5A);
            chkp(m == 0 ? 22'h3F_FFFF : stp(22'h3F_FFFF, m != 2));
        end
        setp(22'h01_2343);
        wr(pft_pkg::OFS_LATCH, 8'h12);
        tbl(1'b1, pft_pkg::PM_POSTINC);
        wr(pft_pkg::OFS_LATCH, 8'h34);
        tbl(1'b1, pft_pkg::PM_KEEP);
        chk(64'(stall_n), 64'h0);
        prog(8'h86, 1'b1);
        chk(64'(stall_d), 64'h8);
        chk(64'(prog_seen.addr), 64'h0001_2340);
        chk(prog_seen.data, 64'hFFFF_FF34_12FF_FFFF);
        chk(64'(prog_seen.byte_en), 64'h0018);
        chk(64'(prog_seen.target), 64'(pft_pkg::TGT_FLASH));
        rdc(pft_pkg::OFS_CONTROL, 8'h84);
        rdc(pft_pkg::OFS_PFLAG_TWO, 8'h10);
        wr(pft_pkg::OFS_PFLAG_TWO, 8'h00);
        rdc(pft_pkg::OFS_PFLAG_TWO, 8'h00);
        prog(8'h86, 1'b1);
        chk(prog_seen.data, 64'hFFFF_FFFF_FFFF_FFFF);
        setp(22'h01_2377);
        prog(8'h96, 1'b1);
        chk(64'(prog_seen.erase), 64'h1);
        chk(64'(prog_seen.addr), 64'h0001_2340);
        rdc(pft_pkg::OFS_CONTROL, 8'h84);
        for (int k = 0; k < 3; k++)
        begin
            prog(tctl[k], 1'b1);
            chk(64'(prog_seen.target), 64'(ttg[k]));
        end
        for (int k = 0; k < 3; k++)
        begin
            prog(ictl[k], k == 1);
            chk(64'(stall_d), 64'h0);
            rdc(pft_pkg::OFS_CONTROL, iexp[k]);
        end
        wr(pft_pkg::OFS_CONTROL, 8'h01);
        rdc(pft_pkg::OFS_LATCH, 8'h77 ^ 8'hC3);
        rdc(pft_pkg::OFS_CONTROL, 8'h00);
        wr(pft_pkg::OFS_CONTROL, 8'h81);
        rdc(pft_pkg::OFS_CONTROL, 8'h80);
        chk(64'(ee_n), 64'h1);
        complete_run();
    end
endmodule
`default_nettype wire
